// ==== rtl/hlt_timer.v ====
/*
  Hardware-limit one-shot and monostable 8-bit timer with an AHB-Lite
  register slave and a PWM drive output.
  Assumes a single clock, AHB-Lite master with single word transfers, and an
  external reset signal that may be asynchronous to the clock.
*/
`timescale 1ns/1ps
`include "hlt_map.vh"

// What this block does
// - Decode two edge one-shot mode codes
// - First edge starts, later edges reset
// - Resume counting two clocks after reset
// - Period match resets count, clears enable
// - Edges ignored while enable is clear
// - Drive active on start and reset edges
// - Drive off at pulse-width match
// - Level reset holds count, edge starts
// - Fresh edge needed after re-enable
// - No drive at period-match clear
// - Monostable starts on edge, stops at period
// - Monostable ignores later edges for drive
// - HL mode counts when enabled and inactive
// - Stay reset until enabled and inactive
// - Drive active on whichever event starts
module hlt_timer (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // External reset signal and PWM drive
  input  wire        ext_rst,
  output reg         pwm_drive
);

  // ==========================================================================
  // State codes.
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_RUN  = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;
  localparam [1:0] ST_HOLD = 2'd3;

  reg        on_q;
  reg  [4:0] mode_q;
  reg  [7:0] period_q;
  reg  [7:0] pwidth_q;
  reg  [7:0] count_q;
  reg  [7:0] count_d;
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg  [1:0] wait_q;
  reg  [1:0] wait_d;
  reg        on_d;
  reg        drive_d;
  reg        sync1_q;
  reg        sync2_q;
  reg        prev_q;
  reg        wr_q;
  reg  [7:0] addr_q;

  // ==========================================================================
  // External signal synchroniser and edge detection.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= ext_rst;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  wire rise = sync2_q & ~prev_q;
  wire fall = ~sync2_q & prev_q;

  // ==========================================================================
  // Mode decode: family flags, reset level and the qualifying trigger.
  reg m_edge;
  reg m_lvl;
  reg m_mono;
  reg m_hl;
  reg rst_lvl_high;
  reg trig;

  always @* begin
    m_edge       = 1'b0;
    m_lvl        = 1'b0;
    m_mono       = 1'b0;
    m_hl         = 1'b0;
    rst_lvl_high = 1'b0;
    trig         = 1'b0;
    case (mode_q)
      `MODE_EDGE_RISE: begin
        m_edge = 1'b1;
        trig   = rise;
      end
      `MODE_EDGE_FALL: begin
        m_edge = 1'b1;
        trig   = fall;
      end
      `MODE_LVL_LOW: begin
        m_lvl = 1'b1;
        trig  = rise;
      end
      `MODE_LVL_HIGH: begin
        m_lvl        = 1'b1;
        rst_lvl_high = 1'b1;
        trig         = fall;
      end
      `MODE_MONO_RISE: begin
        m_mono = 1'b1;
        trig   = rise;
      end
      `MODE_MONO_FALL: begin
        m_mono = 1'b1;
        trig   = fall;
      end
      `MODE_MONO_BOTH: begin
        m_mono = 1'b1;
        trig   = rise | fall;
      end
      `MODE_HL_LOW: begin
        m_hl = 1'b1;
      end
      `MODE_HL_HIGH: begin
        m_hl         = 1'b1;
        rst_lvl_high = 1'b1;
      end
      default: begin
        trig = 1'b0;
      end
    endcase
  end

  // Reset level as seen after the synchroniser.
  wire at_rst_lvl = rst_lvl_high ? sync2_q : ~sync2_q;

  // ==========================================================================
  // Bus write and read request detection.
  wire        wr_data = wr_q;
  wire        wr_ctrl = wr_data && (addr_q == `OFS_CTRL);
  wire        wr_per  = wr_data && (addr_q == `OFS_PERIOD);
  wire        wr_pw   = wr_data && (addr_q == `OFS_PWIDTH);
  wire        rd_req  = hready && hsel && htrans[1] && !hwrite;

  // ==========================================================================
  // Timer control.
  always @* begin
    state_d = state_q;
    count_d = count_q;
    wait_d  = wait_q;
    on_d    = on_q;
    drive_d = pwm_drive;
    case (state_q)
      ST_IDLE: begin
        count_d = 8'h00;
        if (on_q && (m_edge || m_mono) && trig) begin
          state_d = ST_RUN;
          drive_d = 1'b1;
        end else if (on_q && m_lvl && trig && !at_rst_lvl) begin
          state_d = ST_RUN;
          drive_d = 1'b1;
        end else if (on_q && m_hl && !at_rst_lvl) begin
          state_d = ST_RUN;
          drive_d = 1'b1;
        end
      end
      ST_RUN, ST_WAIT: begin
        if (state_q == ST_WAIT) begin
          if (wait_q == `RESTART_CLKS - 2'd1) begin
            state_d = ST_RUN;
          end
          wait_d = wait_q + 2'd1;
        end else begin
          count_d = count_q + 8'h01;
        end
        if (state_q == ST_RUN && count_q == pwidth_q) begin
          drive_d = 1'b0;
        end
        if (state_q == ST_RUN && count_q == period_q) begin
          count_d = m_mono ? count_q : 8'h00;
          state_d = m_mono ? ST_HOLD : ST_IDLE;
          if (!m_mono) begin
            on_d = 1'b0;
          end
        end
        if (m_edge && trig && on_q) begin
          count_d = 8'h00;
          wait_d  = 2'd0;
          state_d = ST_WAIT;
          drive_d = 1'b1;
        end
        if ((m_lvl || m_hl) && at_rst_lvl) begin
          count_d = 8'h00;
          state_d = ST_IDLE;
        end
        if (!on_q) begin
          count_d = 8'h00;
          state_d = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (!on_q) begin
          state_d = ST_IDLE;
          count_d = 8'h00;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (wr_ctrl) begin
      on_d = hwdata[`CTRL_ON_BIT];
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      count_q   <= 8'h00;
      wait_q    <= 2'd0;
      on_q      <= 1'b0;
      pwm_drive <= 1'b0;
    end else begin
      state_q   <= state_d;
      count_q   <= count_d;
      wait_q    <= wait_d;
      on_q      <= on_d;
      pwm_drive <= drive_d;
    end
  end

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture for the following data phase.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q   <= hsel && htrans[1] && hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // ==========================================================================
  // Configuration registers, written at the end of the data phase.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q   <= `RST_MODE;
      period_q <= `RST_PERIOD;
      pwidth_q <= `RST_PWIDTH;
    end else begin
      if (wr_ctrl) begin
        mode_q <= hwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
      end
      if (wr_per) begin
        period_q <= hwdata[7:0];
      end
      if (wr_pw) begin
        pwidth_q <= hwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Read data selection and its register.
  reg [31:0] rdata_d;

  always @* begin
    rdata_d = 32'h00000000;
    case (haddr[7:0])
      `OFS_CTRL:   rdata_d = {19'h00000, mode_q, 7'h00, on_d};
      `OFS_PERIOD: rdata_d = {24'h000000, period_q};
      `OFS_PWIDTH: rdata_d = {24'h000000, pwidth_q};
      `OFS_COUNT:  rdata_d = {24'h000000, count_d};
      `OFS_STATUS: rdata_d = {30'h00000000, drive_d, (state_d != ST_IDLE)};
      default:     rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (rd_req) begin
      hrdata <= rdata_d;
    end
  end

endmodule

// ==== rtl/hlt_map.vh ====
/*
  Constants for the hardware-limit one-shot timer: register offsets, field
  positions, reset values and mode codes.
  Assumes inclusion by the timer design file only.
*/
`ifndef HLT_MAP_VH
`define HLT_MAP_VH

// ==========================================================================
// Register offsets (byte addresses, one aligned word each).
`define OFS_CTRL      8'h00
`define OFS_PERIOD    8'h04
`define OFS_PWIDTH    8'h08
`define OFS_COUNT     8'h0c
`define OFS_STATUS    8'h10

// ==========================================================================
// Field positions.
`define CTRL_ON_BIT   0
`define CTRL_MODE_LSB 8
`define CTRL_MODE_MSB 12
`define ST_RUN_BIT    0
`define ST_DRV_BIT    1

// ==========================================================================
// Reset values.
`define RST_PERIOD    8'hff
`define RST_PWIDTH    8'h00
`define RST_MODE      5'h00

// ==========================================================================
// Mode codes.
`define MODE_EDGE_RISE  5'h0c
`define MODE_EDGE_FALL  5'h0d
`define MODE_LVL_LOW    5'h0e
`define MODE_LVL_HIGH   5'h0f
`define MODE_MONO_RISE  5'h11
`define MODE_MONO_FALL  5'h12
`define MODE_MONO_BOTH  5'h13
`define MODE_HL_LOW     5'h16
`define MODE_HL_HIGH    5'h17

// ==========================================================================
// Timing: restart delay after a later reset edge, in timer clocks.
`define RESTART_CLKS  2'd2

`endif

// ==== dv/hlt_timer_props.sv ====
/*
  Port checker for the hardware-limit one-shot timer.
  Assumes binding to hlt_timer, one clock, active low reset.
*/
`timescale 1ns/1ps
module hlt_timer_props (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        ext_rst,
  input wire        pwm_drive
);
  reg  [3:0] wr_age_q;
  wire       adr_ph = hsel & hready & htrans[1];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Cycles since the last write request.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      wr_age_q <= 4'hf;
    else if (adr_ph & hwrite)
      wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf)
      wr_age_q <= wr_age_q + 4'h1;
  end
  // ==========================================================
  // Properties.
  rdy_always_a: assert property (hreadyout) else $error("ready low");
  resp_okay_a: assert property (!hresp) else $error("error response");
  rdata_hold_a: assert property (!$past(adr_ph & !hwrite) |-> $stable(hrdata))
    else $error("read data moved");
  rdata_pad_a: assert property (hrdata[31:13] == 19'h0) else $error("upper bits");
  rd_unmapped_a: assert property (adr_ph && !hwrite && haddr[7:0] > 8'h10
    |=> hrdata == 32'h0) else $error("unmapped read");
  rst_quiet_a: assert property ($rose(rst_n) |-> !pwm_drive && hrdata == 32'h0)
    else $error("reset values");
  drive_cause_a: assert property ($rose(pwm_drive) |->
    wr_age_q < 4'h8 || $past(ext_rst, 2) != $past(ext_rst, 5)) else $error("drive cause");
  sync_delay_a: assert property ($changed(ext_rst) && wr_age_q == 4'hf
    |=> !$rose(pwm_drive)) else $error("unsynchronised");
  cover property ($rose(pwm_drive));
  cover property ($fell(pwm_drive));
  cover property (adr_ph && !hwrite);
endmodule

bind hlt_timer hlt_timer_props i_props (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .ext_rst(ext_rst), .pwm_drive(pwm_drive));

// ==== dv/hlt_ext_src.sv ====
/*
  External reset signal source beside the timer.
  Assumes the bench sets the wanted level just after a clock edge.
*/
`timescale 1ns/1ps
module hlt_ext_src (
  input  wire clk_sys,
  input  wire lvl,
  output reg  ext_rst
);
  initial ext_rst = 1'b0;
  always @(posedge clk_sys) begin
    ext_rst <= lvl;
  end
endmodule

// ==== dv/hlt_timer_tb.sv ====
/*
  Self-checking bench for the hardware-limit one-shot timer.
  Assumes zero wait state AHB-Lite slave and the external source model.
*/
`timescale 1ns/1ps
module hlt_timer_tb;
  localparam [44:0] MTAB = {5'h17, 5'h16, 5'h13, 5'h12, 5'h11, 5'h0f, 5'h0e, 5'h0d, 5'h0c};
  localparam [8:0]  IDLE_T = 9'b110101010;
  localparam [8:0]  EDGE_T = 9'b101111111;
  localparam [8:0]  ONE_T = 9'b110001111;
  reg         clk_sys = 1'b0;
  reg         rst_n = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         lvl = 1'b0;
  reg  [31:0] rdat;
  reg  [4:0]  m;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        ext_rst;
  wire        pwm_drive;
  integer     miscompares = 0;
  integer     checked = 0;
  integer     cyc = 0;
  integer     i;
  hlt_timer i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_rst(ext_rst),
    .pwm_drive(pwm_drive));
  hlt_ext_src i_ext (.clk_sys(clk_sys), .lvl(lvl), .ext_rst(ext_rst));
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end
  // ==========================================================
  // Tasks.
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rdat = hrdata;
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0);
      chk(rdat, exp);
    end
  endtask
  task setx(input v);
    begin
      repeat (10) @(posedge clk_sys);
      lvl <= v;
    end
  endtask
  task wait_drv(input v);
    integer n;
    begin
      n = 0;
      while (pwm_drive !== v && n < 100) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      chk({31'h0, pwm_drive}, {31'h0, v});
    end
  endtask
  task end_sim;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // ==========================================================
  // Tests.
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'hff);
    rd(8'h0c, 32'h0);
    rd(8'h14, 32'h0);
    xfer(1'b1, 8'h04, 32'h8);
    xfer(1'b1, 8'h08, 32'h3);
    rd(8'h04, 32'h8);
    rd(8'h08, 32'h3);
    $display("test registers done");
    for (i = 0; i < 9; i = i + 1) begin
      m = MTAB[i*5 +: 5];
      xfer(1'b1, 8'h00, {19'h0, m, 8'h0});
      setx(IDLE_T[i]);
      xfer(1'b1, 8'h00, {19'h0, m, 8'h1});
      if (EDGE_T[i]) setx(!IDLE_T[i]);
      wait_drv(1'b1);
      wait_drv(1'b0);
      repeat (12) @(posedge clk_sys);
      rd(8'h00, {19'h0, m, 7'h0, ~ONE_T[i]});
      rd(8'h0c, ONE_T[i] ? 32'h0 : 32'h8);
      chk({31'h0, pwm_drive}, 32'h0);
      if (i < 4) begin
        setx(IDLE_T[i]);
        setx(!IDLE_T[i]);
        repeat (10) @(posedge clk_sys);
        xfer(1'b1, 8'h00, {19'h0, m, 8'h1});
        repeat (10) @(posedge clk_sys);
        rd(8'h0c, 32'h0);
      end
      $display("test mode %h done", m);
    end
    xfer(1'b1, 8'h00, 32'h0c00);
    xfer(1'b1, 8'h04, 32'hff);
    xfer(1'b1, 8'h08, 32'h40);
    setx(1'b0);
    xfer(1'b1, 8'h00, 32'h0c01);
    setx(1'b1);
    wait_drv(1'b1);
    wait_drv(1'b0);
    setx(1'b0);
    setx(1'b1);
    wait_drv(1'b1);
    rd(8'h10, 32'h3);
    wait_drv(1'b0);
    rd(8'h00, 32'h0c01);
    rd(8'h10, 32'h1);
    $display("test retrigger done");
    end_sim;
  end
endmodule
